//--- pkg/spbp_pkg.sv
// spbp_pkg: constants, register map and state codes of the burst port.
// assumes: imported whole by spbp_top, the memory model and the bench.
package spbp_pkg;
	// ==========================================================
	// widths
	localparam int DW      = 16;
	localparam int AW      = 24;
	localparam int ABUS_W  = 7;
	localparam int IDX_W   = 4;
	localparam int DEPTH   = 16;
	localparam int CNT_W   = 5;
	// ==========================================================
	// register byte offsets
	localparam logic [ABUS_W-1:0] REG_CTRL     = 7'h00;
	localparam logic [ABUS_W-1:0] REG_EXT_ADDR = 7'h04;
	localparam logic [ABUS_W-1:0] REG_SRAM_IDX = 7'h08;
	localparam logic [ABUS_W-1:0] REG_LEN      = 7'h0c;
	localparam logic [ABUS_W-1:0] REG_TIMING   = 7'h10;
	localparam logic [ABUS_W-1:0] REG_STATUS   = 7'h14;
	localparam int                SRAM_SEL_BIT = 6;
	// ==========================================================
	// field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_DIR_BIT   = 1;
	localparam int TIM_WWS_LSB    = 0;
	localparam int TIM_RWS_LSB    = 8;
	localparam int TIM_WAD_LSB    = 16;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_DONE_BIT    = 1;
	localparam int ST_ERR_BIT     = 2;
	// ==========================================================
	// reset values and sequence figures
	localparam logic [CNT_W-1:0] WWS_RST    = 5'h05;
	localparam logic [CNT_W-1:0] RWS_RST    = 5'h05;
	localparam logic [3:0]       WAD_RST    = 4'h0;
	localparam logic [CNT_W-1:0] ADDR_EDGE  = 5'h01;
	localparam logic [CNT_W-1:0] MIN_WS     = 5'h02;
	localparam logic [CNT_W:0]   MAX_LEN    = 6'h10;
	// ==========================================================
	// burst sequencer states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_LAUNCH = 2'b01,
		ST_BURST  = 2'b10
	} spbp_state_t;
endpackage

//--- pkg/spbp_pin_if.sv
// spbp_pin_if: raw link inputs and their synchronised copies.
// assumes: one clock and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
interface spbp_pin_if #(parameter int W = 1) (
	input wire logic clk_i,
	input wire logic rst_i
);
	logic [W-1:0] din;
	logic [W-1:0] q3;
	// synchroniser end
	modport sync (input clk_i, input rst_i, input din, output q3);
	// consumer end
	modport user (output din, input q3);
endinterface
`default_nettype wire

//--- design/spbp_sync.sv
// spbp_sync: three-stage synchroniser for inputs from outside the clock.
// assumes: only the last stage is read by other logic.
`timescale 1ns/10ps
`default_nettype none
module spbp_sync (
	// pins in, synchronised out
	spbp_pin_if.sync p
);
	logic [$bits(p.din)-1:0] s1;
	logic [$bits(p.din)-1:0] s2;
	logic [$bits(p.din)-1:0] s3;

	// ==========================================================
	// shift chain, first stage feeds only the second
	always_ff @(posedge p.clk_i or posedge p.rst_i) begin
		if (p.rst_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= p.din;
			s2 <= s1;
			s3 <= s2;
		end
	end
	assign p.q3 = s3;
endmodule
`default_nettype wire

//--- design/spbp_top.sv
// spbp_top: synchronous burst port to a pseudo-static RAM with a
// memory-to-memory channel between a small internal SRAM and the memory.
// assumes: Avalon-MM master on clk_i; bus clock arrives as a pin input.
`timescale 1ns/10ps
`default_nettype none
module spbp_top import spbp_pkg::*; (
	// system
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// register bus
	input  wire logic [ABUS_W-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	// memory link
	input  wire logic              bus_clk_i,
	input  wire logic [DW-1:0]     dq_i,
	output logic      [DW-1:0]     dq_o,
	output logic                   dq_oe_o,
	output logic      [AW-1:0]     addr_o,
	output logic                   addr_latch_n_o,
	output logic                   write_strobe_n_o,
	output logic                   read_strobe_n_o,
	output logic                   bank_select_n_o,
	output logic      [1:0]        byte_lane_selects_o,
	output logic                   burst_addr_advance_o
);
	// ==========================================================
	// synchronised link inputs
	spbp_pin_if #(.W(DW+1)) pin (.clk_i(clk_i), .rst_i(rst_i));
	assign pin.din = {bus_clk_i, dq_i};
	spbp_sync u_sync (.p(pin.sync));

	logic          bclk_d;
	logic          bev;
	logic [DW-1:0] dq_s;
	assign dq_s = pin.q3[DW-1:0];
	// rising edge: stage three high while its registered copy is still low
	assign bev  = pin.q3[DW] & ~bclk_d;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bclk_d <= 1'b0;
		end else begin
			bclk_d <= pin.q3[DW];
		end
	end

	// ==========================================================
	// register and bus state
	logic              waitreq, next_waitreq;
	logic [31:0]       readdata, next_readdata;
	logic [AW-1:0]     ext_addr, next_ext_addr;
	logic [IDX_W-1:0]  sram_idx, next_sram_idx;
	logic [CNT_W:0]    len, next_len;
	logic [CNT_W-1:0]  wws, next_wws;
	logic [CNT_W-1:0]  rws, next_rws;
	logic [3:0]        wad, next_wad;
	logic              dir_cfg, next_dir_cfg;
	logic              done, next_done;
	logic              err, next_err;
	logic              acc_wr, start, cfg_ok, go, bus_mem_we, busy, done_pulse;
	logic [31:0]       rd_mux;

	// burst state
	spbp_state_t       state, next_state;
	logic [CNT_W-1:0]  cnt, next_cnt;
	logic [CNT_W:0]    left, next_left;
	logic [IDX_W-1:0]  idx, next_idx;
	logic              dir_wr, next_dir_wr;
	logic [DW-1:0]     mem [DEPTH], next_mem [DEPTH];
	logic [DW-1:0]     next_dq;
	logic              next_dq_oe;
	logic [AW-1:0]     next_addr;
	logic              next_adv_n, next_we_n, next_rs_n, next_cs_n;
	logic [CNT_W:0]    edge_nx;

	assign busy = (state != ST_IDLE);

	// ==========================================================
	// read data selection
	always_comb begin
		rd_mux = '0;
		if (avs_address_i[SRAM_SEL_BIT]) begin
			rd_mux = {16'h0000, mem[avs_address_i[IDX_W+1:2]]};
		end else begin
			case (avs_address_i)
				REG_CTRL:     rd_mux = {30'h0, dir_cfg, 1'b0};
				REG_EXT_ADDR: rd_mux = {8'h00, ext_addr};
				REG_SRAM_IDX: rd_mux = {28'h0, sram_idx};
				REG_LEN:      rd_mux = {26'h0, len};
				REG_TIMING:   rd_mux = {12'h0, wad, 3'h0, rws, 3'h0, wws};
				REG_STATUS:   rd_mux = {29'h0, err, done, busy};
				default:      rd_mux = '0;
			endcase
		end
	end

	// ==========================================================
	// bus slave: one wait cycle, then the answer
	always_comb begin
		next_waitreq  = ~((avs_read_i | avs_write_i) & waitreq);
		next_readdata = readdata;
		if (avs_read_i & waitreq) begin
			next_readdata = rd_mux;
		end
		acc_wr     = avs_write_i & ~waitreq;
		bus_mem_we = acc_wr & avs_address_i[SRAM_SEL_BIT] & ~busy;
		start      = acc_wr & (avs_address_i == REG_CTRL) & ~busy
		             & avs_writedata_i[CTRL_START_BIT];
		cfg_ok     = (len != '0) && (len <= MAX_LEN) && (wws >= MIN_WS)
		             && (rws >= MIN_WS);
		// a write burst with a late write strobe would miss the address edge
		if (avs_writedata_i[CTRL_DIR_BIT] && (wad != WAD_RST)) begin
			cfg_ok = 1'b0;
		end
		go            = start & cfg_ok;
		next_ext_addr = ext_addr;
		next_sram_idx = sram_idx;
		next_len      = len;
		next_wws      = wws;
		next_rws      = rws;
		next_wad      = wad;
		next_dir_cfg  = dir_cfg;
		next_done     = done;
		next_err      = err;
		if (acc_wr & ~busy) begin
			case (avs_address_i)
				REG_CTRL:     next_dir_cfg  = avs_writedata_i[CTRL_DIR_BIT];
				REG_EXT_ADDR: next_ext_addr = avs_writedata_i[AW-1:0];
				REG_SRAM_IDX: next_sram_idx = avs_writedata_i[IDX_W-1:0];
				REG_LEN:      next_len      = avs_writedata_i[CNT_W:0];
				REG_TIMING: begin
					next_wws = avs_writedata_i[TIM_WWS_LSB +: CNT_W];
					next_rws = avs_writedata_i[TIM_RWS_LSB +: CNT_W];
					next_wad = avs_writedata_i[TIM_WAD_LSB +: 4];
				end
				default: ;
			endcase
		end
		// write one to clear; a new event wins over the clear
		if (acc_wr && (avs_address_i == REG_STATUS)) begin
			if (avs_writedata_i[ST_DONE_BIT]) next_done = 1'b0;
			if (avs_writedata_i[ST_ERR_BIT]) next_err = 1'b0;
		end
		if (start & ~cfg_ok) next_err = 1'b1;
		if (done_pulse) next_done = 1'b1;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			waitreq  <= 1'b1;
			readdata <= '0;
			ext_addr <= '0;
			sram_idx <= '0;
			len      <= '0;
			wws      <= WWS_RST;
			rws      <= RWS_RST;
			wad      <= WAD_RST;
			dir_cfg  <= 1'b0;
			done     <= 1'b0;
			err      <= 1'b0;
		end else begin
			waitreq  <= next_waitreq;
			readdata <= next_readdata;
			ext_addr <= next_ext_addr;
			sram_idx <= next_sram_idx;
			len      <= next_len;
			wws      <= next_wws;
			rws      <= next_rws;
			wad      <= next_wad;
			dir_cfg  <= next_dir_cfg;
			done     <= next_done;
			err      <= next_err;
		end
	end
	assign avs_waitrequest_o = waitreq;
	assign avs_readdata_o    = readdata;

	// ==========================================================
	// burst sequencer, leaves idle on an accepted start (go), then steps once per bus-clock rise
	always_comb begin
		next_state  = state;
		next_cnt    = cnt;
		next_left   = left;
		next_idx    = idx;
		next_dir_wr = dir_wr;
		next_mem    = mem;
		next_dq     = dq_o;
		next_dq_oe  = dq_oe_o;
		next_addr   = addr_o;
		next_adv_n  = addr_latch_n_o;
		next_we_n   = write_strobe_n_o;
		next_rs_n   = read_strobe_n_o;
		next_cs_n   = bank_select_n_o;
		done_pulse  = 1'b0;
		edge_nx     = {1'b0, cnt} + 6'h01;
		if (bus_mem_we) begin
			next_mem[avs_address_i[IDX_W+1:2]] = avs_writedata_i[DW-1:0];
		end
		unique case (state)
			ST_IDLE: begin
				// no request line: the channel runs as soon as it is started
				if (go) begin
					next_state  = ST_LAUNCH;
					next_dir_wr = avs_writedata_i[CTRL_DIR_BIT];
					next_idx    = sram_idx;
					next_left   = len;
				end
			end
			ST_LAUNCH: begin
				if (bev) begin
					next_cs_n  = 1'b0;
					next_adv_n = 1'b0;
					next_addr  = ext_addr;
					// strobe level sits with the address for the same edge
					next_we_n  = ~dir_wr;
					next_cnt   = ADDR_EDGE;
					next_state = ST_BURST;
				end
			end
			ST_BURST: begin
				if (bev) begin
					next_adv_n = 1'b1;
					if (cnt != '1) next_cnt = edge_nx[CNT_W-1:0];
					if (dir_wr) begin
						// source is SRAM, one halfword per edge from the latency edge
						if ((left != '0) && (edge_nx >= {1'b0, wws})) begin
							next_dq    = mem[idx];
							next_dq_oe = 1'b1;
							next_idx   = idx + 4'h1;
							next_left  = left - 6'h01;
						end else if ((left == '0) && (cnt >= wws)) begin
							next_state = ST_IDLE;
						end
					end else begin
						next_rs_n = 1'b0;
						// destination is SRAM, one halfword per edge after latency
						if (cnt >= rws) begin
							next_mem[idx] = dq_s;
							next_idx      = idx + 4'h1;
							next_left     = left - 6'h01;
							if (left == 6'h01) next_state = ST_IDLE;
						end
					end
					// strobes released only when the whole burst is over
					if (next_state == ST_IDLE) begin
						next_cs_n  = 1'b1;
						next_we_n  = 1'b1;
						next_rs_n  = 1'b1;
						next_dq_oe = 1'b0;
						done_pulse = 1'b1;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state                <= ST_IDLE;
			cnt                  <= '0;
			left                 <= '0;
			idx                  <= '0;
			dir_wr               <= 1'b0;
			mem                  <= '{default: '0};
			dq_o                 <= '0;
			dq_oe_o              <= 1'b0;
			addr_o               <= '0;
			addr_latch_n_o       <= 1'b1;
			write_strobe_n_o     <= 1'b1;
			read_strobe_n_o      <= 1'b1;
			bank_select_n_o      <= 1'b1;
			byte_lane_selects_o  <= 2'b00;
			burst_addr_advance_o <= 1'b1;
		end else begin
			state                <= next_state;
			cnt                  <= next_cnt;
			left                 <= next_left;
			idx                  <= next_idx;
			dir_wr               <= next_dir_wr;
			mem                  <= next_mem;
			dq_o                 <= next_dq;
			dq_oe_o              <= next_dq_oe;
			addr_o               <= next_addr;
			addr_latch_n_o       <= next_adv_n;
			write_strobe_n_o     <= next_we_n;
			read_strobe_n_o      <= next_rs_n;
			bank_select_n_o      <= next_cs_n;
			byte_lane_selects_o  <= 2'b00;
			burst_addr_advance_o <= 1'b1;
		end
	end

	// ==========================================================
	// checks
	logic [DW-1:0] mem_at_idx;
	logic          wr_refuse;
	assign mem_at_idx = mem[idx];
	assign wr_refuse  = start & avs_writedata_i[CTRL_DIR_BIT] & (wad != WAD_RST);

	property p_rd_addr;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_LAUNCH) && bev && !dir_wr |=> !addr_latch_n_o && write_strobe_n_o;
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("read began with strobe low");

	property p_wr_addr;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_LAUNCH) && bev && dir_wr
		|=> !addr_latch_n_o && !write_strobe_n_o && !bank_select_n_o;
	endproperty
	a_wr_addr: assert property (p_wr_addr) else $error("write strobe not with address");

	property p_wad;
		@(posedge clk_i) disable iff (rst_i)
		wr_refuse |=> (state == ST_IDLE) && err;
	endproperty
	a_wad: assert property (p_wad) else $error("late write strobe not refused");

	property p_word;
		@(posedge clk_i) disable iff (rst_i)
		dq_oe_o |-> (byte_lane_selects_o == 2'b00) && !write_strobe_n_o;
	endproperty
	a_word: assert property (p_word) else $error("partial write driven");

	property p_lanes;
		@(posedge clk_i) disable iff (rst_i)
		!bank_select_n_o |-> (byte_lane_selects_o == 2'b00);
	endproperty
	a_lanes: assert property (p_lanes) else $error("byte lane raised in cycle");

	property p_first;
		@(posedge clk_i) disable iff (rst_i)
		$rose(dq_oe_o) |-> (cnt == wws) && !bank_select_n_o;
	endproperty
	a_first: assert property (p_first) else $error("first datum off latency edge");

	property p_baa;
		@(posedge clk_i) disable iff (rst_i)
		burst_addr_advance_o;
	endproperty
	a_baa: assert property (p_baa) else $error("address advance driven");

	property p_m2m;
		@(posedge clk_i) disable iff (rst_i)
		go |=> (state == ST_LAUNCH) ##[1:16] !bank_select_n_o;
	endproperty
	a_m2m: assert property (p_m2m) else $error("channel did not start");

	property p_src;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_BURST) && bev && dir_wr && (left != '0) && (edge_nx >= {1'b0, wws})
		|=> dq_o == $past(mem_at_idx);
	endproperty
	a_src: assert property (p_src) else $error("write datum not from SRAM");

	property p_rate;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_BURST) && bev && !dir_wr && (cnt >= rws)
		|=> (idx == $past(idx) + 4'h1) && (mem[$past(idx)] == $past(dq_s));
	endproperty
	a_rate: assert property (p_rate) else $error("read halfword not stored");

	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
		$rose(read_strobe_n_o) |-> $rose(bank_select_n_o) && (state == ST_IDLE);
	endproperty
	a_hold: assert property (p_hold) else $error("read strobe released early");

	property p_cont;
		@(posedge clk_i) disable iff (rst_i)
		dq_oe_o && bev && (left != '0) |=> dq_oe_o && (idx == $past(idx) + 4'h1);
	endproperty
	a_cont: assert property (p_cont) else $error("write burst stalled");

	c_wr_done: cover property (@(posedge clk_i) disable iff (rst_i) done_pulse && dir_wr);
	c_rd_done: cover property (@(posedge clk_i) disable iff (rst_i) done_pulse && !dir_wr);
	c_refuse:  cover property (@(posedge clk_i) disable iff (rst_i) start && !cfg_ok);
endmodule
`default_nettype wire

//--- tb/spbp_psram_model.sv
// spbp_psram_model: behavioural synchronous pseudo-static memory, 64 halfwords.
// assumes: fixed latency LAT counted from the address edge; free-running bus clock.
`timescale 1ns/10ps
`default_nettype none
module spbp_psram_model import spbp_pkg::*; #(parameter int LAT = 4) (
	// link pins as the memory sees them
	input  wire logic          clk_i,
	input  wire logic          cs_n_i,
	input  wire logic          latch_n_i,
	input  wire logic          we_n_i,
	input  wire logic          rd_n_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] din_i,
	input  wire logic          oe_i,
	input  wire logic [1:0]    lanes_i,
	// data back to the device and fault count
	output logic      [DW-1:0] dout_o,
	output int                 fault_cnt_o
);
	// =======================================================
	// storage
	logic [DW-1:0] mem [64];
	logic [5:0]    ptr;
	logic          wr_mode;
	int            edge_cnt;
	initial begin
		for (int i = 0; i < 64; i++) mem[i] = 16'ha000 + 16'(i);
		dout_o = 16'h0000;
		edge_cnt = 0;
		fault_cnt_o = 0;
		wr_mode = 1'b0;
		ptr = 6'h00;
	end
	// address capture, then write data taken from the latency edge on
	always @(posedge clk_i) begin
		if (cs_n_i) edge_cnt <= 0;
		else if (!latch_n_i) begin
			ptr <= addr_i[5:0];
			wr_mode <= !we_n_i;
			edge_cnt <= 1;
		end else begin
			edge_cnt <= edge_cnt + 1;
			if (wr_mode && edge_cnt >= LAT) begin
				mem[ptr] <= din_i;
				ptr <= ptr + 6'h01;
				if (!oe_i || lanes_i !== 2'b00) fault_cnt_o <= fault_cnt_o + 1;
			end else if (!wr_mode && edge_cnt >= LAT && rd_n_i !== 1'b0) begin
				fault_cnt_o <= fault_cnt_o + 1;
			end
		end
	end
	// read data launched half a bus clock ahead of each sampling edge;
	// the burst offset comes from the edge count, so ptr keeps one driver
	always @(negedge clk_i) begin
		if (!cs_n_i && !wr_mode && edge_cnt >= LAT) begin
			dout_o <= mem[ptr + 6'(edge_cnt - LAT)];
		end else dout_o <= ~dout_o; // released bus never holds its value
	end
endmodule
`default_nettype wire

//--- tb/spbp_bench.sv
// spbp_bench: self-checking bench of the burst port with a memory model.
// assumes: 40 MHz system clock, 200 ns bus clock, Avalon master tasks.
`timescale 1ns/10ps
`default_nettype none
module spbp_bench import spbp_pkg::*;;
	// =======================================================
	// signals
	logic          clk_i, rst_i, bus_clk_i;
	logic [6:0]    avs_address_i;
	logic          avs_read_i, avs_write_i;
	logic [31:0]   avs_writedata_i, avs_readdata_o, q;
	logic          avs_waitrequest_o, dq_oe_o, addr_latch_n_o, write_strobe_n_o;
	logic          read_strobe_n_o, bank_select_n_o, burst_addr_advance_o, cs_q;
	logic [DW-1:0] dq_i, dq_o;
	logic [AW-1:0] addr_o;
	logic [1:0]    byte_lane_selects_o;
	int            error_cnt = 0, n_compared = 0, cs_falls = 0, falls, faults;
	typedef struct packed {logic wr; logic [6:0] a; logic [31:0] d; logic [31:0] e;} spbp_row_t;
	localparam spbp_row_t ROWS [9] = '{
		'{1'b0, REG_TIMING, 32'h0, 32'h00000505}, '{1'b0, REG_STATUS, 32'h0, 32'h0},
		'{1'b0, REG_CTRL, 32'h0, 32'h0}, '{1'b1, 7'h20, 32'hffffffff, 32'h0},
		'{1'b0, 7'h20, 32'h0, 32'h0}, '{1'b1, REG_EXT_ADDR, 32'hff123456, 32'h0},
		'{1'b0, REG_EXT_ADDR, 32'h0, 32'h00123456}, '{1'b1, 7'h44, 32'h0000beef, 32'h0},
		'{1'b0, 7'h44, 32'h0, 32'h0000beef}};
	localparam logic [31:0] BAD [4][3] = '{'{32'h10505, 32'h2, 32'h3},
		'{32'h505, 32'h0, 32'h3}, '{32'h505, 32'h11, 32'h1}, '{32'h501, 32'h2, 32'h3}};
	// =======================================================
	// design and memory model
	spbp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.bus_clk_i(bus_clk_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .addr_o(addr_o),
		.addr_latch_n_o(addr_latch_n_o), .write_strobe_n_o(write_strobe_n_o),
		.read_strobe_n_o(read_strobe_n_o), .bank_select_n_o(bank_select_n_o),
		.byte_lane_selects_o(byte_lane_selects_o), .burst_addr_advance_o(burst_addr_advance_o));
	spbp_psram_model #(.LAT(4)) u_mem (.clk_i(bus_clk_i), .cs_n_i(bank_select_n_o),
		.latch_n_i(addr_latch_n_o), .we_n_i(write_strobe_n_o), .rd_n_i(read_strobe_n_o),
		.addr_i(addr_o), .din_i(dq_o), .oe_i(dq_oe_o), .lanes_i(byte_lane_selects_o),
		.dout_o(dq_i), .fault_cnt_o(faults));
	// =======================================================
	// clocks
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		bus_clk_i = 1'b0;
		forever #100 bus_clk_i = ~bus_clk_i;
	end
	// pin watch: bank select falls, lane selects and address advance
	always @(posedge clk_i) begin
		cs_q <= bank_select_n_o;
		if (cs_q === 1'b1 && bank_select_n_o === 1'b0) cs_falls <= cs_falls + 1;
		if (!rst_i && (byte_lane_selects_o !== 2'b00
			|| burst_addr_advance_o !== 1'b1)) begin
			error_cnt++;
			$display("MISMATCH %0t lane select or advance pin active", $time);
		end
	end
	// =======================================================
	// tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		check(32'(n < 50), 32'h1, "bus answer");
	endtask
	task automatic burst(input logic [31:0] ea, input logic [31:0] ix, input logic [31:0] len,
		input logic [31:0] ctl);
		bus(1'b1, REG_EXT_ADDR, ea);
		bus(1'b1, REG_SRAM_IDX, ix);
		bus(1'b1, REG_LEN, len);
		falls = cs_falls;
		bus(1'b1, REG_CTRL, ctl);
	endtask
	task automatic wait_done();
		for (int i = 0; i < 300; i++) begin
			bus(1'b0, REG_STATUS, 32'h0);
			if (q[ST_BUSY_BIT] === 1'b0) break;
		end
		check(q & 32'h7, 32'h2, "status after burst");
		check(32'(cs_falls - falls), 32'h1, "one bank select fall");
		bus(1'b1, REG_STATUS, 32'h6);
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// =======================================================
	// watchdog
	initial begin
		#2000000;
		error_cnt++;
		$display("MISMATCH %0t watchdog expired", $time);
		test_done();
	end
	// =======================================================
	// main sequence
	initial begin
		rst_i = 1'b1;
		avs_address_i = 7'h00;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ROWS[i]) begin
			bus(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
			if (!ROWS[i].wr) check(q, ROWS[i].e, "register row");
		end
		$display("test registers done");
		// write burst of three halfwords wrapping the internal index
		bus(1'b1, 7'h78, 32'h1111);
		bus(1'b1, 7'h7c, 32'h2222);
		bus(1'b1, 7'h40, 32'h3333);
		burst(32'h10, 32'he, 32'h3, 32'h3);
		bus(1'b0, REG_STATUS, 32'h0);
		check(32'(q[ST_BUSY_BIT]), 32'h1, "busy at once");
		wait_done();
		check(32'(u_mem.mem[16]), 32'h1111, "first write datum");
		check(32'(u_mem.mem[17]), 32'h2222, "second write datum");
		check(32'(u_mem.mem[18]), 32'h3333, "third write datum");
		check(32'(u_mem.mem[19]), 32'ha013, "past burst end");
		$display("test write burst done");
		// full-length read burst into a wrapping index
		burst(32'h20, 32'h3, 32'h10, 32'h1);
		wait_done();
		for (int k = 0; k < 16; k++) begin
			bus(1'b0, 7'(7'h40 + 7'(((3 + k) % 16) * 4)), 32'h0);
			check(q, 32'ha020 + 32'(k), "read burst datum");
		end
		check(32'(faults), 32'h0, "memory side faults");
		$display("test read burst done");
		// refused starts leave the link idle and raise the error flag
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, REG_TIMING, BAD[i][0]);
			burst(32'h0, 32'h0, BAD[i][1], BAD[i][2]);
			repeat (24) @(posedge clk_i);
			bus(1'b0, REG_STATUS, 32'h0);
			check(q & 32'h7, 32'h4, "refused start");
			check(32'(cs_falls - falls), 32'h0, "no burst on refusal");
			bus(1'b1, REG_STATUS, 32'h4);
		end
		// read latency moved off its reset value so the reset check below can trip
		bus(1'b1, REG_TIMING, 32'h605);
		$display("test refusals done");
		// reset in mid burst returns pins and registers to idle
		burst(32'h30, 32'h0, 32'h10, 32'h3);
		for (int i = 0; i < 200 && bank_select_n_o !== 1'b0; i++) @(posedge clk_i);
		repeat (60) @(posedge clk_i);
		rst_i <= 1'b1;
		#1;
		check(32'({bank_select_n_o, write_strobe_n_o, dq_oe_o}), 32'h6, "pins in reset");
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, REG_TIMING, 32'h0);
		check(q, 32'h505, "timing after reset");
		$display("test mid reset done");
		test_done();
	end
endmodule
`default_nettype wire
